//--- hw/plc_fifo.sv
// value fifo module is kept with the rest of the logic in plc_top.sv

//--- hw/plc_pkg.sv
// constants for the printer listing control block
package plc_pkg;
    // register byte offsets
    localparam logic [7:0]  ADDR_HEADING   = 8'h00;
    localparam logic [7:0]  ADDR_CONTROL   = 8'h04;
    localparam logic [7:0]  ADDR_COMMAND   = 8'h08;
    localparam logic [7:0]  ADDR_STATUS    = 8'h0c;
    localparam logic [7:0]  ADDR_VALUE     = 8'h10;
    // control fields
    localparam int          CTL_CNT_PRINT  = 0;
    localparam int          CTL_PRN_EN     = 1;
    localparam int          CTL_SERIAL_OP  = 2;
    // command fields
    localparam int          CMD_RESTART    = 0;
    // status fields
    localparam int          ST_PRN_ON      = 0;
    localparam int          ST_FIFO_FULL   = 1;
    localparam int          ST_FIFO_EMPTY  = 2;
    localparam int          ST_REJECT      = 3;
    // values and limits
    localparam logic [13:0] HEADING_RESET  = 14'h03e8;
    localparam logic [13:0] HEADING_MAX    = 14'h270f;
    localparam logic [13:0] COUNTER_START  = 14'h0001;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          DATA_W         = 24;
    // output record kinds
    localparam logic [1:0]  KIND_HEADING   = 2'h0;
    localparam logic [1:0]  KIND_COUNTER   = 2'h1;
    localparam logic [1:0]  KIND_VALUE     = 2'h2;
endpackage

//--- hw/plc_top.sv
// printer listing control: apb registers, value fifo, listing sequencer
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/10ps
module plc_top
    import plc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        meas_valid,
    output logic             meas_ready,
    input  wire logic [23:0] meas_data,
    output logic             prn_valid,
    input  wire logic        prn_ready,
    output logic      [1:0]  prn_kind,
    output logic      [23:0] prn_data,
    output logic             prn_connect
);
    typedef enum logic [1:0] {S_IDLE, S_HEAD, S_CNT, S_VAL} plc_state_t;

    logic [13:0] heading_interval;
    logic        cnt_print;
    logic        prn_enable;
    logic        serial_op;
    logic        reject;
    logic [13:0] value_counter;
    logic [13:0] since_heading;
    logic        need_heading;
    logic [23:0] value_hold;
    plc_state_t  state;
    logic        wr_acc;
    logic        rd_acc;
    logic        f_valid;
    logic        f_ready;
    logic [23:0] f_data;
    logic        in_valid;
    logic        in_ready;
    logic        prn_active;
    logic        take;
    logic        rec_done;
    logic [31:0] next_prdata;

    // apb: zero wait states, error on unmapped address
    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign pslverr = psel && penable && !(paddr == ADDR_HEADING
        || paddr == ADDR_CONTROL || paddr == ADDR_COMMAND
        || paddr == ADDR_STATUS || paddr == ADDR_VALUE);

    // printer live only when enabled and not in serial operation
    assign prn_active  = prn_enable && !serial_op;
    assign prn_connect = prn_active;

    // settings registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            heading_interval <= HEADING_RESET;
            cnt_print        <= 1'b1;
            prn_enable       <= 1'b0;
            serial_op        <= 1'b0;
            reject           <= 1'b0;
        end
        else if (wr_acc && paddr == ADDR_HEADING)
        begin
            // zero is no valid interval either
            if (pwdata[31:0] > 32'(HEADING_MAX) || pwdata == 32'h0)
                reject <= 1'b1;
            else
                heading_interval <= pwdata[13:0];
        end
        else if (wr_acc && paddr == ADDR_CONTROL)
        begin
            cnt_print <= pwdata[CTL_CNT_PRINT];
            serial_op <= pwdata[CTL_SERIAL_OP];
            // enable refused while the serial interface is selected
            if (pwdata[CTL_PRN_EN] && pwdata[CTL_SERIAL_OP])
            begin
                prn_enable <= 1'b0;
                reject     <= 1'b1;
            end
            else
                prn_enable <= pwdata[CTL_PRN_EN];
        end
        else if (rd_acc && paddr == ADDR_STATUS)
            reject <= 1'b0;                           // cleared by reading
    end

    // read mux
    always_comb
    begin
        next_prdata = 32'h0;
        case (paddr)
            ADDR_HEADING: next_prdata = {18'h0, heading_interval};
            ADDR_CONTROL:
            begin
                next_prdata[CTL_CNT_PRINT] = cnt_print;
                next_prdata[CTL_PRN_EN]    = prn_enable;
                next_prdata[CTL_SERIAL_OP] = serial_op;
            end
            ADDR_STATUS:
            begin
                next_prdata[ST_PRN_ON]     = prn_active;
                next_prdata[ST_FIFO_FULL]  = !in_ready;
                next_prdata[ST_FIFO_EMPTY] = !f_valid;
                next_prdata[ST_REJECT]     = reject;
            end
            ADDR_VALUE: next_prdata = {18'h0, value_counter};
            default: next_prdata = 32'h0;
        endcase
    end

    // read data captured in the setup cycle: a flop output that still
    // answers in the access cycle, so no wait state is needed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata <= next_prdata;
    end

    // values requested over the parallel bus enter only while printing
    assign in_valid   = meas_valid && prn_active;
    assign meas_ready = in_ready && prn_active;

    plc_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (meas_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    assign take     = (state == S_IDLE) && f_valid;
    assign f_ready  = take;
    assign rec_done = prn_valid && prn_ready;

    // listing sequencer: heading when due, optional counter, value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state      <= S_IDLE;
            prn_valid  <= 1'b0;
            prn_kind   <= KIND_HEADING;
            prn_data   <= 24'h0;
            value_hold <= 24'h0;
        end
        else
        begin
            case (state)
                S_IDLE:
                    if (take)
                    begin
                        value_hold <= f_data;
                        prn_valid  <= 1'b1;
                        if (need_heading)
                        begin
                            state    <= S_HEAD;
                            prn_kind <= KIND_HEADING;
                            prn_data <= {10'h0, heading_interval};
                        end
                        else if (cnt_print)
                        begin
                            state    <= S_CNT;
                            prn_kind <= KIND_COUNTER;
                            prn_data <= {10'h0, value_counter};
                        end
                        else
                        begin
                            state    <= S_VAL;
                            prn_kind <= KIND_VALUE;
                            prn_data <= f_data;
                        end
                    end
                S_HEAD:
                    if (rec_done)
                    begin
                        if (cnt_print)
                        begin
                            state    <= S_CNT;
                            prn_kind <= KIND_COUNTER;
                            prn_data <= {10'h0, value_counter};
                        end
                        else
                        begin
                            state    <= S_VAL;
                            prn_kind <= KIND_VALUE;
                            prn_data <= value_hold;
                        end
                    end
                S_CNT:
                    if (rec_done)
                    begin
                        state    <= S_VAL;
                        prn_kind <= KIND_VALUE;
                        prn_data <= value_hold;
                    end
                S_VAL:
                    if (rec_done)
                    begin
                        state     <= S_IDLE;
                        prn_valid <= 1'b0;
                    end
                default:
                begin
                    state     <= S_IDLE;
                    prn_valid <= 1'b0;
                end
            endcase
        end
    end

    // counters; restart wins over a value completing in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            value_counter <= COUNTER_START;
            since_heading <= 14'h0;
            need_heading  <= 1'b1;
        end
        else
        begin
            if (wr_acc && paddr == ADDR_COMMAND && pwdata[CMD_RESTART])
                value_counter <= COUNTER_START;
            else if (state == S_VAL && rec_done)
                value_counter <= value_counter + 14'h1;
            if (state == S_HEAD && rec_done)
            begin
                since_heading <= 14'h0;
                need_heading  <= 1'b0;
            end
            else if (state == S_VAL && rec_done)
            begin
                since_heading <= since_heading + 14'h1;
                if (since_heading + 14'h1 >= heading_interval)
                    need_heading <= 1'b1;
            end
        end
    end
endmodule

// parameterised valid/ready fifo for measured values
module plc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // honest full and empty from the fill count
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    // storage needs no reset
    always_ff @(posedge pclk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // pointers wrap at depth
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

//--- test/plc_printer_model.sv
// serial printer model: takes records, slow at random or stalled on demand
`timescale 1ns/10ps
module plc_printer_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic stall,
    output logic      prn_ready
);
    int seed = 78;
    // a real printer pauses often, so ready drops about a third of cycles
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            prn_ready <= 1'b0;
        else
            prn_ready <= !stall && ($random(seed) % 3 != 0);
endmodule

//--- test/plc_top_sva.sv
// assertions on the printer listing control ports
`timescale 1ns/10ps
module plc_top_sva
    import plc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        meas_valid,
    input wire logic        meas_ready,
    input wire logic [23:0] meas_data,
    input wire logic        prn_valid,
    input wire logic        prn_ready,
    input wire logic [1:0]  prn_kind,
    input wire logic [23:0] prn_data,
    input wire logic        prn_connect
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase and record handshake
    wire ac = psel && penable;
    wire tk = prn_valid && prn_ready;
    wire cw = ac && pwrite && paddr == ADDR_CONTROL;
    sequence s_restart;
        ac && pwrite && paddr == ADDR_COMMAND && pwdata[CMD_RESTART];
    endsequence
    sequence s_read_count;
        ac && !pwrite && paddr == ADDR_VALUE;
    endsequence
    // no value may be taken between restart and read, else count moves
    property p_restart;
        s_restart ##1 (!psel && !tk) ##1 (psel && !penable && !tk)
            ##1 s_read_count |-> prdata == 32'h1;
    endproperty
    property p_hold;
        prn_valid && !prn_ready |=> prn_valid && $stable(prn_kind)
            && $stable(prn_data);
    endproperty
    property p_gap;
        tk && prn_kind == KIND_VALUE |=> !prn_valid;
    endproperty
    property p_enter;
        meas_ready |-> prn_connect;
    endproperty
    property p_serial;
        cw && pwdata[CTL_SERIAL_OP] |=> !prn_connect;
    endproperty
    property p_enable;
        cw && pwdata[CTL_PRN_EN] && !pwdata[CTL_SERIAL_OP] |=> prn_connect;
    endproperty
    property p_status;
        ac && !pwrite && paddr == ADDR_STATUS |->
            prdata[ST_PRN_ON] == prn_connect;
    endproperty
    property p_heading;
        ac && !pwrite && paddr == ADDR_HEADING |-> prdata[31:14] == 0
            && prdata[13:0] != 0 && prdata[13:0] <= HEADING_MAX;
    endproperty
    a_restart: assert property (p_restart)
        else $error("counter not one after restart");
    a_hold: assert property (p_hold)
        else $error("record changed while stalled");
    a_gap: assert property (p_gap)
        else $error("no gap after value record");
    a_enter: assert property (p_enter)
        else $error("value taken while printer off");
    a_serial: assert property (p_serial)
        else $error("printer on in serial operation");
    a_enable: assert property (p_enable)
        else $error("printer not connected after enable");
    a_status: assert property (p_status)
        else $error("status printer bit wrong");
    a_heading: assert property (p_heading)
        else $error("heading interval out of range");
endmodule
bind plc_top plc_top_sva u_plc_top_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_valid(meas_valid),
    .meas_ready(meas_ready), .meas_data(meas_data),
    .prn_valid(prn_valid), .prn_ready(prn_ready), .prn_kind(prn_kind),
    .prn_data(prn_data), .prn_connect(prn_connect)
);

//--- test/plc_top_tb_top.sv
// self-checking bench for the printer listing control block
`timescale 1ns/10ps
module plc_top_tb_top;
    import plc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, meas_valid = 0, stall = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv;
    logic [23:0] meas_data = 0, prn_data;
    logic [1:0]  prn_kind;
    logic        pready, pslverr, erv, meas_ready;
    logic        prn_valid, prn_ready, prn_connect;
    logic [25:0] gotq[$], exq[$];
    int          seed = 78, num_errors = 0, comparisons = 0, cycles = 0;
    int          intv = 1000, cp = 1, ctr = 1, cnt = 0, pend = 1, acc;
    always #10 pclk = ~pclk;
    plc_top u_plc_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas_valid(meas_valid),
        .meas_ready(meas_ready), .meas_data(meas_data),
        .prn_valid(prn_valid), .prn_ready(prn_ready), .prn_kind(prn_kind),
        .prn_data(prn_data), .prn_connect(prn_connect)
    );
    plc_printer_model u_plc_printer_model (
        .pclk(pclk), .presetn(presetn), .stall(stall),
        .prn_ready(prn_ready)
    );
    // record monitor and hang guard
    always @(posedge pclk)
    begin
        if (prn_valid && prn_ready)
            gotq.push_back({prn_kind, prn_data});
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            wrap_up;
        end
    end
    task wrap_up;
        $display("counts: %0d compares, %0d mismatches", comparisons,
            num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value at %0t: reg %h not %h", $time, g, e);
        end
    endtask
    task chk_rec(input logic [25:0] g, input logic [25:0] e);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value at %0t: rec %h not %h", $time, g, e);
        end
    endtask
    // one apb transfer; waits for pready however late it comes
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    function logic [25:0] rec(input logic [1:0] k, input int d);
        return {k, d[23:0]};
    endfunction
    // listing order: heading when due, counter if on, then the value
    task expect_value(input logic [23:0] v);
        if (pend)
            exq.push_back(rec(KIND_HEADING, intv));
        pend = 0;
        if (cp)
            exq.push_back(rec(KIND_COUNTER, ctr));
        exq.push_back(rec(KIND_VALUE, {8'h0, v}));
        ctr++;
        cnt++;
        pend = (cnt == intv);
        cnt = pend ? 0 : cnt;
    endtask
    task push(input int n, input int lim);
        acc = 0;
        meas_valid <= 1'b1;
        meas_data <= 24'($random(seed));
        repeat (lim)
        begin
            @(posedge pclk);
            if (meas_ready === 1'b1 && meas_valid && acc < n)
            begin
                expect_value(meas_data);
                acc++;
                meas_data <= 24'($random(seed));
            end
            meas_valid <= (acc < n);
        end
        meas_valid <= 1'b0;
    endtask
    task drain;
        repeat (600) if (gotq.size() < exq.size()) @(posedge pclk);
        repeat (4) @(posedge pclk);
        chk(gotq.size(), exq.size());
        while (exq.size() > 0 && gotq.size() > 0)
            chk_rec(gotq.pop_front(), exq.pop_front());
        gotq.delete();
        exq.delete();
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_HEADING, 32'h3e8);
        rd(ADDR_CONTROL, 32'h1);
        rd(ADDR_VALUE, 32'h1);
        apb(1'b1, ADDR_HEADING, 32'h2710);
        rd(ADDR_HEADING, 32'h3e8);
        rd(ADDR_STATUS, 32'hc);
        apb(1'b1, ADDR_HEADING, 32'h270f);
        rd(ADDR_HEADING, 32'h270f);
        $display("test registers done");
        apb(1'b1, ADDR_CONTROL, 32'h6);
        rd(ADDR_CONTROL, 32'h4);
        chk(prn_connect, 1'b0);
        rd(ADDR_STATUS, 32'hc);
        apb(1'b1, ADDR_HEADING, 32'h3);
        apb(1'b1, ADDR_CONTROL, 32'h3);
        intv = 3;
        rd(ADDR_STATUS, 32'h5);
        chk(prn_connect, 1'b1);
        push(5, 40);
        drain;
        rd(ADDR_VALUE, 32'h6);
        $display("test listing done");
        apb(1'b1, ADDR_COMMAND, 32'h1);
        rd(ADDR_VALUE, 32'h1);
        ctr = 1;
        apb(1'b1, ADDR_CONTROL, 32'h2);
        cp = 0;
        rd(ADDR_CONTROL, 32'h2);
        stall <= 1'b1;
        push(12, 16);
        chk(acc >= 8, 1'b1);
        chk(meas_ready, 1'b0);
        rd(ADDR_STATUS, 32'h3);
        stall <= 1'b0;
        drain;
        $display("test fifo done");
        apb(1'b0, 8'h20, 32'h0);
        chk(erv, 1'b1);
        chk(rdv, 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h0);
        push(1, 4);
        chk(acc, 0);
        rd(ADDR_STATUS, 32'h4);
        $display("test disable done");
        wrap_up;
    end
endmodule
